/* File: tviu_top.sv */
// Summary of operation
// - Thirteen sources, each flag, enable, vector; priority for all but power fail, which is always high
// - External 0 and 1 select edge or level
// - Edge mode samples per machine cycle, falling
// - Edge external 0/1 flag cleared on entry
// - Level mode flag follows pin, not cleared on entry
// - External 2-5 edge only, software cleared
// - Hardware clear select clears external 2-5
// - Timer 0/1 flags cleared on vectoring
// - Timer 2 request ORs two flags, kept
// - Watchdog needs its enable; software clears
// - Serial request ORs rx/tx, never cleared by hardware
// - Software may write every request flag
// - Individual enables; global spares power fail
// - Two levels; low never preempts high
// - Fixed order within a level
// - Sample and resolve every machine cycle
// - Call only on last cycle, unrestricted
// - Denied requests are not remembered
// - Call pushes PC, loads vector, no status
// - Vector table per source
// - Interrupt exit ends the current routine
// - Plain subroutine exit leaves service active
// - Hardware call lasts four machine cycles
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tviu_top #(
  parameter int NSRC = tviu_pkg::NSRC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // External pins, active low requests
  input wire logic [5:0] ext_pin_i,
  // Peripheral flag set pulses
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic timer2_overflow_i,
  input wire logic timer2_ext_event_i,
  input wire logic uart0_rx_done_i,
  input wire logic uart0_tx_done_i,
  input wire logic uart1_rx_done_i,
  input wire logic uart1_tx_done_i,
  input wire logic watchdog_timeout_flag_i,
  input wire logic power_fail_flag_i,
  // Instruction sequencer
  input wire logic mc_last_i,
  input wire logic call_blocked_i,
  input wire logic int_exit_i,
  output logic mc_tick_o,
  output logic call_o,
  output logic call_active_o,
  output logic [15:0] vector_o,
  output logic [1:0] in_service_o
);

  typedef struct packed {
    logic [31:0] readdata;
    logic waitreq;
    logic [7:0] int_enable_reg;
    logic [7:0] ext_enable_reg2;
    logic [7:0] priority_reg;
    logic [7:0] ext_priority_reg2;
    logic [15:0] flags;
    logic [5:0] ctrl;
    logic [5:0] pin_prev;
    logic [7:0] mc_cnt;
    logic tick;
    tviu_pkg::tviu_call_state_t call_state;
    logic [7:0] call_cnt;
    logic call;
    logic [3:0] call_src;
    logic [15:0] vector;
    logic [1:0] in_service;
  } tviu_state_t;

  localparam logic [7:0] MC_LAST = 8'(tviu_pkg::CLKS_PER_MC - 1);
  localparam logic [7:0] CALL_LEN = 8'(tviu_pkg::CALL_CLKS);

  tviu_state_t st;
  tviu_state_t next_st;
  logic [NSRC-1:0] src_flag;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_req;
  logic [NSRC-1:0] src_high;
  logic win_valid;
  logic [3:0] win_idx;
  logic win_level;
  logic wr_en;
  logic issue;
  logic [31:0] rd_mux;
  logic [15:0] hw_clr;
  logic [15:0] hw_set;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  tviu_resolve #(
    .NSRC(NSRC)
  ) tviu_resolve_i (
    .req_i(src_req),
    .high_i(src_high),
    .in_service_i(st.in_service),
    .valid_o(win_valid),
    .idx_o(win_idx),
    .level_o(win_level)
  );

  always_comb begin
    // timer 2 request ORs overflow and event
    // serial requests OR rx and tx done
    src_flag = {st.flags[tviu_pkg::F_PFAIL], st.flags[tviu_pkg::F_WDT],
                st.flags[tviu_pkg::F_EXT2 + 3 -: 4],
                st.flags[tviu_pkg::F_U1RX] | st.flags[tviu_pkg::F_U1TX],
                st.flags[tviu_pkg::F_TF2] | st.flags[tviu_pkg::F_TIMER2_EXT_EVENT],
                st.flags[tviu_pkg::F_U0RX] | st.flags[tviu_pkg::F_U0TX],
                st.flags[tviu_pkg::F_TF1], st.flags[tviu_pkg::F_EXT1],
                st.flags[tviu_pkg::F_TF0], st.flags[tviu_pkg::F_EXT0]};
    // watchdog enable is bit 4 of second enable
    src_en = {st.ext_enable_reg2[5:0], st.int_enable_reg[6:0]};
    src_high = {1'b1, st.ext_priority_reg2[4:0], st.priority_reg[6:0]};
    for (int i = 0; i < NSRC; i++) begin
      src_req[i] = src_flag[i] && src_en[i] &&
                   (st.int_enable_reg[tviu_pkg::IE_GLOBAL] || (i == tviu_pkg::SRC_PFAIL));
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i == tviu_pkg::OFS_INT_ENABLE) begin
      rd_mux[7:0] = st.int_enable_reg;
    end else if (avs_address_i == tviu_pkg::OFS_EXT_ENABLE2) begin
      rd_mux[7:0] = st.ext_enable_reg2;
    end else if (avs_address_i == tviu_pkg::OFS_PRIORITY) begin
      rd_mux[7:0] = st.priority_reg;
    end else if (avs_address_i == tviu_pkg::OFS_EXT_PRIORITY2) begin
      rd_mux[7:0] = st.ext_priority_reg2;
    end else if (avs_address_i == tviu_pkg::OFS_FLAGS) begin
      rd_mux[15:0] = st.flags;
    end else if (avs_address_i == tviu_pkg::OFS_CTRL) begin
      rd_mux[5:0] = st.ctrl;
    end else if (avs_address_i == tviu_pkg::OFS_STATUS) begin
      rd_mux = {st.vector, 13'h0000, (st.call_state == tviu_pkg::TVIU_CALL), st.in_service};
    end
  end

  always_comb begin
    next_st = st;
    next_st.call = 1'b0;
    // Bus: one wait cycle, then data and acceptance
    wr_en = avs_write_i && !st.waitreq;
    next_st.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.readdata = rd_mux;
    end
    if (wr_en) begin
      if (avs_address_i == tviu_pkg::OFS_INT_ENABLE) begin
        next_st.int_enable_reg = 8'(merge({24'h0, st.int_enable_reg}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == tviu_pkg::OFS_EXT_ENABLE2) begin
        next_st.ext_enable_reg2 = 8'(merge({24'h0, st.ext_enable_reg2}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == tviu_pkg::OFS_PRIORITY) begin
        next_st.priority_reg = 8'(merge({24'h0, st.priority_reg}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == tviu_pkg::OFS_EXT_PRIORITY2) begin
        next_st.ext_priority_reg2 = 8'(merge({24'h0, st.ext_priority_reg2}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == tviu_pkg::OFS_FLAGS) begin
        next_st.flags = 16'(merge({16'h0, st.flags}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == tviu_pkg::OFS_CTRL) begin
        next_st.ctrl = 6'(merge({26'h0, st.ctrl}, avs_writedata_i, avs_byteenable_i));
      end
    end

    // Machine cycle divider
    next_st.mc_cnt = (st.mc_cnt == MC_LAST) ? 8'h00 : st.mc_cnt + 8'h01;
    next_st.tick = (next_st.mc_cnt == MC_LAST);

    // poll on the machine cycle tick
    // last cycle and no restricted instruction
    // no pending latch, decided afresh each tick
    issue = st.tick && (st.call_state == tviu_pkg::TVIU_IDLE) && win_valid &&
            mc_last_i && !call_blocked_i;

    // Hardware clears on entry
    hw_clr = 16'h0000;
    if (issue) begin
      if (win_idx == 4'(tviu_pkg::SRC_EXT0) && st.ctrl[tviu_pkg::C_TRIG0]) begin
        hw_clr[tviu_pkg::F_EXT0] = 1'b1;
      end
      if (win_idx == 4'(2) && st.ctrl[tviu_pkg::C_TRIG1]) begin
        hw_clr[tviu_pkg::F_EXT1] = 1'b1;
      end
      if (win_idx == 4'(1)) begin
        hw_clr[tviu_pkg::F_TF0] = 1'b1;
      end
      if (win_idx == 4'(3)) begin
        hw_clr[tviu_pkg::F_TF1] = 1'b1;
      end
      // optional hardware clear for external 2-5
      for (int k = 0; k < 4; k++) begin
        if (win_idx == 4'(tviu_pkg::SRC_EXT2 + k) && st.ctrl[tviu_pkg::C_HWCLR + k]) begin
          hw_clr[tviu_pkg::F_EXT2 + k] = 1'b1;
        end
      end
    end
    next_st.flags = next_st.flags & ~hw_clr;

    // Hardware sets win over any clear
    hw_set = 16'h0000;
    hw_set[tviu_pkg::F_TF0] = timer0_overflow_i;
    hw_set[tviu_pkg::F_TF1] = timer1_overflow_i;
    hw_set[tviu_pkg::F_TF2] = timer2_overflow_i;
    hw_set[tviu_pkg::F_TIMER2_EXT_EVENT] = timer2_ext_event_i;
    hw_set[tviu_pkg::F_U0RX] = uart0_rx_done_i;
    hw_set[tviu_pkg::F_U0TX] = uart0_tx_done_i;
    hw_set[tviu_pkg::F_U1RX] = uart1_rx_done_i;
    hw_set[tviu_pkg::F_U1TX] = uart1_tx_done_i;
    // watchdog and power fail cleared only by software
    hw_set[tviu_pkg::F_WDT] = watchdog_timeout_flag_i;
    hw_set[tviu_pkg::F_PFAIL] = power_fail_flag_i;
    if (st.tick) begin
      next_st.pin_prev = ext_pin_i;
      for (int k = 0; k < 4; k++) begin
        hw_set[tviu_pkg::F_EXT2 + k] = st.pin_prev[2 + k] && !ext_pin_i[2 + k];
      end
      hw_set[tviu_pkg::F_EXT0] = st.ctrl[tviu_pkg::C_TRIG0] ? (st.pin_prev[0] && !ext_pin_i[0]) : !ext_pin_i[0];
      hw_set[tviu_pkg::F_EXT1] = st.ctrl[tviu_pkg::C_TRIG1] ? (st.pin_prev[1] && !ext_pin_i[1]) : !ext_pin_i[1];
      // level mode flag tracks the pin
      if (!st.ctrl[tviu_pkg::C_TRIG0]) begin
        next_st.flags[tviu_pkg::F_EXT0] = 1'b0;
      end
      if (!st.ctrl[tviu_pkg::C_TRIG1]) begin
        next_st.flags[tviu_pkg::F_EXT1] = 1'b0;
      end
    end
    next_st.flags = next_st.flags | hw_set;

    // interrupt exit ends the highest active level
    // plain subroutine exit has no input here
    if (int_exit_i) begin
      if (st.in_service[1]) begin
        next_st.in_service[1] = 1'b0;
      end else begin
        next_st.in_service[0] = 1'b0;
      end
    end

    case (st.call_state)
      tviu_pkg::TVIU_IDLE: begin
        if (issue) begin
          // sequencer pushes PC and loads vector
          next_st.call = 1'b1;
          next_st.call_src = win_idx;
          next_st.vector = tviu_pkg::VECTORS[win_idx];
          next_st.in_service[win_level] = 1'b1;
          next_st.call_cnt = CALL_LEN;
          next_st.call_state = tviu_pkg::TVIU_CALL;
        end
      end
      tviu_pkg::TVIU_CALL: begin
        next_st.call_cnt = st.call_cnt - 8'h01;
        if (st.call_cnt == 8'h01) begin
          next_st.call_state = tviu_pkg::TVIU_IDLE;
        end
      end
      default: begin
        next_st.call_state = tviu_pkg::TVIU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{readdata: 32'h0000_0000, waitreq: 1'b1,
              int_enable_reg: tviu_pkg::RST_ENABLE, ext_enable_reg2: tviu_pkg::RST_ENABLE,
              priority_reg: tviu_pkg::RST_PRIORITY, ext_priority_reg2: tviu_pkg::RST_PRIORITY,
              flags: tviu_pkg::RST_FLAGS, ctrl: tviu_pkg::RST_CTRL, pin_prev: 6'h3f,
              mc_cnt: 8'h00, tick: 1'b0, call_state: tviu_pkg::TVIU_IDLE, call_cnt: 8'h00,
              call: 1'b0, call_src: 4'h0, vector: 16'h0000, in_service: 2'b00};
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_o = st.readdata;
  assign avs_waitrequest_o = st.waitreq;
  assign mc_tick_o = st.tick;
  assign call_o = st.call;
  assign call_active_o = (st.call_state == tviu_pkg::TVIU_CALL);
  assign vector_o = st.vector;
  assign in_service_o = st.in_service;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_call_cond;
    call_o |-> $past(mc_last_i && !call_blocked_i && st.tick);
  endproperty
  a_call_cond: assert property (p_call_cond) else $error("call issued outside last machine cycle");

  property p_call_len;
    $rose(call_active_o) |-> call_o ##15 call_active_o ##1 !call_active_o;
  endproperty
  a_call_len: assert property (p_call_len) else $error("hardware call length wrong");

  property p_vec_ext0;
    call_o && (st.call_src == 4'h0) |-> vector_o == 16'h0003;
  endproperty
  a_vec_ext0: assert property (p_vec_ext0) else $error("external 0 vector wrong");

  property p_edge_set;
    st.tick && st.pin_prev[2] && !ext_pin_i[2] |=> st.flags[tviu_pkg::F_EXT2];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("external 2 edge not flagged");

  property p_edge_clr;
    call_o && st.call_src == 4'h0 && st.ctrl[tviu_pkg::C_TRIG0] && !$past(wr_en) &&
      !$past(st.pin_prev[0] && !ext_pin_i[0]) |-> !st.flags[tviu_pkg::F_EXT0];
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge flag kept on entry");

  property p_no_preempt;
    $past(in_service_o[1]) |-> !call_o;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("high service preempted");

  property p_serial_kept;
    call_o && !$past(wr_en) |-> (st.flags[9:4] & $past(st.flags[9:4])) == $past(st.flags[9:4]);
  endproperty
  a_serial_kept: assert property (p_serial_kept) else $error("serial or timer 2 flag cleared");

  property p_global;
    call_o |-> $past(st.int_enable_reg[tviu_pkg::IE_GLOBAL]) || st.call_src == 4'(tviu_pkg::SRC_PFAIL);
  endproperty
  a_global: assert property (p_global) else $error("call with global enable off");

  property p_exit;
    int_exit_i && in_service_o == 2'b11 && !call_o |=> in_service_o == 2'b01;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not end high level");

endmodule
`default_nettype wire

/* File: tviu_pkg.sv */
package tviu_pkg;

  // Machine cycle and hardware call timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MC_PERIOD_NS = 40;
  localparam int CLKS_PER_MC = (MC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CALL_MCS = 4;
  localparam int CALL_CLKS = CALL_MCS * CLKS_PER_MC;

  // Sources
  localparam int NSRC = 13;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_SER0 = 4;
  localparam int SRC_TMR2 = 5;
  localparam int SRC_SER1 = 6;
  localparam int SRC_EXT2 = 7;
  localparam int SRC_PFAIL = 12;

  // Flag bit positions
  localparam int F_EXT0 = 0;
  localparam int F_TF0 = 1;
  localparam int F_EXT1 = 2;
  localparam int F_TF1 = 3;
  localparam int F_U0RX = 4;
  localparam int F_U0TX = 5;
  localparam int F_TF2 = 6;
  localparam int F_TIMER2_EXT_EVENT = 7;
  localparam int F_U1RX = 8;
  localparam int F_U1TX = 9;
  localparam int F_EXT2 = 10;
  localparam int F_WDT = 14;
  localparam int F_PFAIL = 15;

  // Control register fields and the global enable bit
  localparam int C_TRIG0 = 0;
  localparam int C_TRIG1 = 1;
  localparam int C_HWCLR = 2;
  localparam int IE_GLOBAL = 7;

  // Register byte offsets
  localparam logic [4:0] OFS_INT_ENABLE = 5'h00;
  localparam logic [4:0] OFS_EXT_ENABLE2 = 5'h04;
  localparam logic [4:0] OFS_PRIORITY = 5'h08;
  localparam logic [4:0] OFS_EXT_PRIORITY2 = 5'h0c;
  localparam logic [4:0] OFS_FLAGS = 5'h10;
  localparam logic [4:0] OFS_CTRL = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIORITY = 8'h00;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [5:0] RST_CTRL = 6'h00;

  // Vector table, index 12 first, index 0 last
  localparam logic [NSRC-1:0][15:0] VECTORS = {
    16'h0033, 16'h0063, 16'h005b, 16'h0053, 16'h004b, 16'h0043, 16'h003b,
    16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};

  typedef enum logic {TVIU_IDLE, TVIU_CALL} tviu_call_state_t;

endpackage

/* File: tviu_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
module tviu_resolve #(
  parameter int NSRC = 13
) (
  // Requests
  input wire logic [NSRC-1:0] req_i,
  input wire logic [NSRC-1:0] high_i,
  input wire logic [1:0] in_service_i,
  // Winner
  output logic valid_o,
  output logic [3:0] idx_o,
  output logic level_o
);

  always_comb begin
    valid_o = 1'b0;
    idx_o = 4'h0;
    level_o = 1'b0;
    // low pass, blocked by any service
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_i[i] && !high_i[i] && (in_service_i == 2'b00)) begin
        valid_o = 1'b1;
        idx_o = 4'(i);
        level_o = 1'b0;
      end
    end
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_i[i] && high_i[i] && !in_service_i[1]) begin
        valid_o = 1'b1;
        idx_o = 4'(i);
        level_o = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: tviu_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tviu_seq_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Block tick and bench control
  input wire logic mc_tick_i,
  input wire logic last_en_i,
  input wire logic slow_i,
  input wire logic blk_i,
  input wire logic ret_i,
  input wire logic plain_i,
  // Sequencer status to the block
  output logic mc_last_o,
  output logic call_blocked_o,
  output var logic int_exit_o
);
  logic odd;
  assign mc_last_o = last_en_i & (~slow_i | odd);
  assign call_blocked_o = blk_i;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      odd <= 1'b0;
      int_exit_o <= 1'b0;
    end else begin
      if (mc_tick_i) begin
        odd <= ~odd;
      end
      // exit signalled only on interrupt return
      int_exit_o <= ret_i & ~plain_i;
    end
  end
endmodule
`default_nettype wire

/* File: tviu_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tviu_tb_top;
  localparam logic [15:0] HW_SET = 16'hc3fa;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [5:0] pins = 6'h3f;
  logic [15:0] pulse = 16'h0;
  logic last_en = 1'b1;
  logic slow = 1'b0;
  logic blk = 1'b0;
  logic ret = 1'b0;
  logic plain = 1'b0;
  logic [31:0] rdata;
  logic wreq, mc_last, blocked, int_exit, mc_tick, call, active;
  logic [15:0] vector;
  logic [1:0] in_service;
  logic [31:0] vq[$];
  logic [31:0] rq[$];
  logic [31:0] v;
  logic [15:0] fl;
  int error_cnt = 0;
  int n_tests = 0;
  int acnt = 0;
  int tgap = 0;
  int f;
  int fb[13] = '{0, 1, 2, 3, 4, 6, 8, 10, 11, 12, 13, 14, 15};

  always #5 sys_clk_i = ~sys_clk_i;

  tviu_top tviu_top_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .ext_pin_i(pins), .timer0_overflow_i(pulse[1]), .timer1_overflow_i(pulse[3]),
    .timer2_overflow_i(pulse[6]), .timer2_ext_event_i(pulse[7]), .uart0_rx_done_i(pulse[4]),
    .uart0_tx_done_i(pulse[5]), .uart1_rx_done_i(pulse[8]), .uart1_tx_done_i(pulse[9]),
    .watchdog_timeout_flag_i(pulse[14]), .power_fail_flag_i(pulse[15]), .mc_last_i(mc_last),
    .call_blocked_i(blocked), .int_exit_i(int_exit), .mc_tick_o(mc_tick), .call_o(call),
    .call_active_o(active), .vector_o(vector), .in_service_o(in_service));

  tviu_seq_model tviu_seq_model_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .mc_tick_i(mc_tick),
    .last_en_i(last_en), .slow_i(slow), .blk_i(blk), .ret_i(ret), .plain_i(plain), .mc_last_o(mc_last),
    .call_blocked_o(blocked), .int_exit_o(int_exit));

  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("BAD %0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k = 0;
    adr <= a;
    wr_s <= w;
    rd_s <= ~w;
    wd <= d;
    @(posedge sys_clk_i);
    while (wreq !== 1'b0) begin
      k++;
      if (k > 50) hang();
      @(posedge sys_clk_i);
    end
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rq.push_back(e);
    if (a == 5'h18) chk(32'(in_service), 32'(e[1:0]));
    bus(1'b0, a, 32'h0);
  endtask

  task automatic en(input logic [12:0] m, input logic g);
    wr(5'h00, {24'h0, g, m[6:0]});
    wr(5'h04, {26'h0, m[12:7]});
  endtask

  task automatic pri(input logic [12:0] m);
    wr(5'h08, {25'h0, m[6:0]});
    wr(5'h0c, {27'h0, m[11:7]});
  endtask

  task automatic setf(input int b);
    if (HW_SET[b] && $urandom % 2 == 1) begin
      pulse[b] <= 1'b1;
      @(posedge sys_clk_i);
      pulse <= 16'h0;
      @(posedge sys_clk_i);
    end else begin
      wr(5'h10, 32'(1 << b));
    end
  endtask

  task automatic wt(input int n);
    int k = 0;
    while (vq.size() > n) begin
      k++;
      if (k > 300) hang();
      @(posedge sys_clk_i);
    end
    repeat (tviu_pkg::CALL_CLKS + 2) @(posedge sys_clk_i);
  endtask

  task automatic rt(input logic p);
    plain <= p;
    ret <= 1'b1;
    @(posedge sys_clk_i);
    ret <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  function automatic logic [31:0] vec(input int i);
    return (i == 12) ? 32'h33 : 32'(3 + 8 * ((i < 6) ? i : i + 1));
  endfunction

  always @(negedge sys_clk_i) begin
    if (call === 1'b1) begin
      chk({16'h0, vector}, (vq.size() != 0) ? vq.pop_front() : 32'hffffffff);
    end
    if (active === 1'b1) begin
      acnt++;
    end else if (acnt != 0) begin
      chk(acnt, tviu_pkg::CALL_CLKS);
      acnt = 0;
    end
    if (rd_s === 1'b1 && wreq === 1'b0) begin
      chk(rdata, rq.pop_front());
    end
    if (mc_tick === 1'b1) begin
      if (tgap > 0) chk(tgap, tviu_pkg::CLKS_PER_MC);
      tgap = 1;
    end else if (tgap > 0) begin
      tgap++;
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    hang();
  end

  initial begin
    void'($urandom(32'h964e631f));
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    wr(5'h1c, 32'hffffffff);
    for (int a = 0; a < 32; a += 4) begin
      rd(5'(a), 32'h0);
    end
    wr(5'h14, 32'h3);
    for (int i = 0; i < 13; i++) begin
      en(13'(1 << i), 1'b1);
      f = fb[i] + ((i > 3 && i < 7) ? int'($urandom % 2) : 0);
      vq.push_back(vec(i));
      setf(f);
      wt(0);
      rd(5'h10, (f < 4) ? 32'h0 : 32'(1 << f));
      rt(1'b1);
      v = vec(i);
      rd(5'h18, {v[15:0], 14'h0, ((i == 12) ? 2'b10 : 2'b01)});
      wr(5'h10, 32'h0);
      rt(1'b0);
    end
    en(13'h0fff, 1'b1);
    for (int i = 0; i < 12; i++) begin
      vq.push_back(vec(i));
    end
    fl = 16'h7fff;
    wr(5'h10, {16'h0, fl});
    for (int i = 0; i < 12; i++) begin
      wt(11 - i);
      fl &= ~(16'(1 << fb[i]) | ((i > 3 && i < 7) ? 16'(2 << fb[i]) : 16'h0));
      wr(5'h10, {16'h0, fl});
      rt(1'b0);
    end
    en(13'h1fff, 1'b0);
    vq.push_back(32'h33);
    wr(5'h10, 32'h8002);
    wt(0);
    wr(5'h10, 32'h2);
    rt(1'b0);
    repeat (40) @(posedge sys_clk_i);
    vq.push_back(vec(1));
    en(13'h1fff, 1'b1);
    wt(0);
    rt(1'b0);
    pri(13'h0002);
    vq.push_back(vec(0));
    wr(5'h10, 32'h1);
    wt(0);
    vq.push_back(vec(1));
    wr(5'h10, 32'h2);
    wt(0);
    wr(5'h10, 32'h10);
    repeat (40) @(posedge sys_clk_i);
    rd(5'h18, {16'h000b, 14'h0, 2'b11});
    rt(1'b0);
    repeat (40) @(posedge sys_clk_i);
    rd(5'h18, {16'h000b, 14'h0, 2'b01});
    vq.push_back(vec(4));
    rt(1'b0);
    wt(0);
    wr(5'h10, 32'h0);
    rt(1'b0);
    pri(13'h0);
    last_en <= 1'b0;
    wr(5'h10, 32'h2);
    repeat (40) @(posedge sys_clk_i);
    wr(5'h10, 32'h0);
    last_en <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    blk <= 1'b1;
    wr(5'h10, 32'h2);
    repeat (40) @(posedge sys_clk_i);
    vq.push_back(vec(1));
    blk <= 1'b0;
    wt(0);
    rt(1'b0);
    slow <= 1'b1;
    vq.push_back(vec(1));
    wr(5'h10, 32'h2);
    wt(0);
    slow <= 1'b0;
    rt(1'b0);
    wr(5'h14, 32'h15);
    for (int p = 0; p < 6; p++) begin
      vq.push_back(vec((p < 2) ? 2 * p : p + 5));
      // pin held low past a machine cycle
      pins[p] <= 1'b0;
      wt(0);
      rd(5'h10, (p == 1) ? 32'h4 : (p == 3 || p == 5) ? 32'(1 << (8 + p)) : 32'h0);
      if (p == 1) begin
        vq.push_back(vec(2));
        rt(1'b0);
        wt(0);
      end
      pins[p] <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      wr(5'h10, 32'h0);
      rt(1'b0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
